// >>> hw/flash_cfg_pkg.sv
// Purpose: shared constants, types and states of the serial flash configuration master
// Assumes: core_clk at 25 MHz, synchronous active-high reset
// Notes: stream is command, header word, payload words, then a 16-bit crc
package flash_cfg_pkg;

  localparam int CLK_PERIOD_NS     = 40;
  localparam int CLK_MHZ           = 25;
  localparam int PROG_MIN_NS       = 300;
  localparam int PROG_MIN_CYC      = (PROG_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int CLEAR_TIME_NS_DEF = 1_000_000;
  localparam int PAYLOAD_WORDS_DEF = 16;

  localparam logic [2:0]  MODE_SERIAL_FLASH = 3'h1;
  localparam logic [7:0]  FLASH_READ_CMD    = 8'h03;
  localparam logic [23:0] FLASH_START_ADDR  = 24'h00_0000;
  localparam int          CMD_BITS          = 32;
  localparam int          WORD_BITS         = 32;
  localparam int          CRC_BITS          = 16;
  localparam logic [15:0] CRC_POLY          = 16'h1021;
  localparam logic [15:0] CRC_INIT          = 16'hFFFF;
  localparam int          HDR_FAST_BIT      = 0;

  // half periods of config clock in core_clk cycles, index is rate option
  localparam logic [4:0] HALF_SLOW   = 5'h18;
  localparam logic [4:0] HALF_RATE1  = 5'h0C;
  localparam logic [4:0] HALF_RATE2  = 5'h06;
  localparam logic [4:0] HALF_RATE3  = 5'h04;

  // synchroniser bit positions and reset value
  localparam int         SYNC_SERIAL = 0;
  localparam int         SYNC_INIT   = 1;
  localparam int         SYNC_PROG   = 2;
  localparam int         SYNC_MODE   = 3;
  localparam logic [5:0] SYNC_RESET  = 6'h06;

  typedef enum logic [3:0] {
    ST_HOLD, ST_CLEAR, ST_WAIT_INIT, ST_CMD, ST_HEADER,
    ST_PAYLOAD, ST_CRC, ST_DONE, ST_CRC_ERR, ST_BAD_MODE
  } state_e;

  typedef struct packed {
    logic flashSelectN;
    logic configClockOut;
    logic serialOut;
    logic chainOut;
  } flashPins_s;

endpackage

// >>> hw/pin_sync.sv
// Purpose: three-stage synchroniser for pins from outside the core_clk domain
// Assumes: synchronous active-high reset
// Notes: output moves only when second and third stages agree
`timescale 1ns/1ps
module pin_sync
  import flash_cfg_pkg::*;
(
  // clock and reset
  input  wire logic       core_clk,
  input  wire logic       rst,
  // pins in, stable levels out
  input  wire logic [5:0] pinIn,
  output logic      [5:0] pinStable
);

  logic [5:0] stage1;
  logic [5:0] stage2;
  logic [5:0] stage3;

  genvar b;
  generate
    for (b = 0; b < 6; b++)
    begin : g_bit
      always_ff @(posedge core_clk)
      begin
        if (rst)
        begin
          stage1[b]    <= SYNC_RESET[b];
          stage2[b]    <= SYNC_RESET[b];
          stage3[b]    <= SYNC_RESET[b];
          pinStable[b] <= SYNC_RESET[b];
        end
        else
        begin
          stage1[b] <= pinIn[b];
          stage2[b] <= stage1[b];
          stage3[b] <= stage2[b];
          // agreement filter rejects a single-cycle glitch
          if (stage2[b] == stage3[b])
            pinStable[b] <= stage3[b];
        end
      end
    end
  endgenerate

endmodule // pin_sync

// >>> hw/clock_rate_divider.sv
// Purpose: half-period tick for the configuration clock
// Assumes: halfPeriod of 2 or more
// Notes: counter restarts whenever run drops
`timescale 1ns/1ps
module clock_rate_divider
  import flash_cfg_pkg::*;
(
  // clock and reset
  input  wire logic       core_clk,
  input  wire logic       rst,
  // control
  input  wire logic       run,
  input  wire logic [4:0] halfPeriod,
  // one-cycle enable at each config clock edge
  output logic            tick
);

  logic [4:0] count;
  wire        atEnd = (count >= halfPeriod - 5'h1);

  assign tick = run & atEnd;

  always_ff @(posedge core_clk)
  begin
    if (rst || !run || atEnd)
      count <= 5'h0;
    else
      count <= count + 5'h1;
  end

endmodule // clock_rate_divider

// >>> hw/serial_flash_config_master.sv
// Purpose: loads configuration from a serial flash at power-on or reprogram
// Assumes: core_clk 25 MHz; flash answers read with header, payload and crc
// Notes: clear time is a parameter so simulation can shorten it
`timescale 1ns/1ps
module serial_flash_config_master
  import flash_cfg_pkg::*;
#(
  parameter int CLEAR_TIME_NS = CLEAR_TIME_NS_DEF,
  parameter int PAYLOAD_WORDS = PAYLOAD_WORDS_DEF
)
(
  // clock and reset
  input  wire logic        core_clk,
  input  wire logic        rst,
  // flash link and chain pins
  output flashPins_s       pinOut,
  output flashPins_s       pinOe,
  input  wire logic        serialIn,
  // open-drain init indicator
  input  wire logic        initIn,
  output logic             initDrive,
  output logic             initOe,
  // open-drain done flag
  output logic             doneDrive,
  output logic             doneOe,
  // reprogram and straps
  input  wire logic        reprogram_n,
  input  wire logic [2:0]  modeSelect,
  input  wire logic [1:0]  clock_rate_option,
  // loaded data stream
  output logic [31:0]      configWord,
  output logic             configWordValid,
  // status
  output logic             configDone,
  output logic             crcError,
  output logic             modeError,
  output logic             fastRate
);

  localparam int CLEAR_CYC = (CLEAR_TIME_NS * CLK_MHZ + 999) / 1000;
  localparam logic [19:0] CLEAR_LAST = 20'(CLEAR_CYC - 1);
  localparam logic [3:0]  PROG_MIN   = 4'(PROG_MIN_CYC);
  localparam logic [15:0] WORD_LAST  = 16'(PAYLOAD_WORDS - 1);

  state_e      state;
  state_e      next_state;
  logic [19:0] clearCnt;
  logic [19:0] next_clearCnt;
  logic [3:0]  progLowCnt;
  logic        sclk;
  logic        next_sclk;
  logic [5:0]  bitCnt;
  logic [5:0]  next_bitCnt;
  logic [15:0] wordCnt;
  logic [15:0] next_wordCnt;
  logic [31:0] cmdShift;
  logic [31:0] next_cmdShift;
  logic [31:0] inShift;
  logic [31:0] next_inShift;
  logic [15:0] crc;
  logic [15:0] next_crc;
  logic        chainBit;
  logic        next_chainBit;
  logic        next_fastRate;
  logic        next_wordValid;
  logic [31:0] next_configWord;
  logic        tick;
  logic [5:0]  syncOut;
  logic [4:0]  rateHalf;

  // decoded pin levels
  wire        serialSync = syncOut[SYNC_SERIAL];
  wire        initSync   = syncOut[SYNC_INIT];
  wire        progSync   = syncOut[SYNC_PROG];
  wire [2:0]  modeSync   = syncOut[SYNC_MODE +: 3];
  wire        progHeld   = (progLowCnt == PROG_MIN);
  wire        linkActive = (state == ST_CMD) || (state == ST_HEADER) ||
                           (state == ST_PAYLOAD) || (state == ST_CRC);
  wire        riseEdge   = tick & ~sclk;
  wire        fallEdge   = tick & sclk;
  wire        crcFb      = crc[15] ^ serialSync;
  wire [15:0] crcStep    = {crc[14:0], 1'b0} ^ (crcFb ? CRC_POLY : 16'h0000);
  wire [31:0] inNext     = {inShift[30:0], serialSync};
  wire        pinsFloat  = (state == ST_HOLD);
  wire        afterDone  = (state == ST_DONE);
  wire [5:0]  phaseLen   = (state == ST_CRC) ? 6'(CRC_BITS) : 6'(WORD_BITS);
  wire        phaseEnd   = fallEdge && (bitCnt == phaseLen);

  pin_sync u_sync (
    .core_clk  (core_clk),
    .rst       (rst),
    .pinIn     ({modeSelect, reprogram_n, initIn, serialIn}),
    .pinStable (syncOut)
  );

  // lowest rate until the header asks for more
  assign rateHalf = !fastRate ? HALF_SLOW :
                    (clock_rate_option == 2'h1) ? HALF_RATE1 :
                    (clock_rate_option == 2'h2) ? HALF_RATE2 :
                    (clock_rate_option == 2'h3) ? HALF_RATE3 : HALF_SLOW;

  clock_rate_divider u_div (
    .core_clk   (core_clk),
    .rst        (rst),
    .run        (linkActive),
    .halfPeriod (rateHalf),
    .tick       (tick)
  );

  // pin drive values
  assign pinOut.flashSelectN   = ~linkActive;
  assign pinOut.configClockOut = sclk;
  assign pinOut.serialOut      = cmdShift[31];
  assign pinOut.chainOut       = chainBit;

  // everything floats under reprogram; after done the pins belong to user logic
  assign pinOe.flashSelectN    = ~pinsFloat & ~afterDone;
  assign pinOe.configClockOut  = ~pinsFloat & ~afterDone;
  assign pinOe.serialOut       = ~pinsFloat & ~afterDone;
  assign pinOe.chainOut        = ~pinsFloat & ~afterDone;

  assign initDrive  = 1'b0;
  assign initOe     = (state == ST_CLEAR) || (state == ST_CRC_ERR);
  assign doneDrive  = 1'b0;
  assign doneOe     = ~pinsFloat & ~afterDone;
  assign configDone = afterDone;
  assign crcError   = (state == ST_CRC_ERR);
  assign modeError  = (state == ST_BAD_MODE);

  // reprogram low-time filter, saturates at the minimum pulse
  always_ff @(posedge core_clk)
  begin
    if (rst || progSync)
      progLowCnt <= 4'h0;
    else if (!progHeld)
      progLowCnt <= progLowCnt + 4'h1;
  end

  always_comb
  begin
    next_state      = state;
    next_clearCnt   = clearCnt;
    next_sclk       = sclk;
    next_bitCnt     = bitCnt;
    next_wordCnt    = wordCnt;
    next_cmdShift   = cmdShift;
    next_inShift    = inShift;
    next_crc        = crc;
    next_chainBit   = chainBit;
    next_fastRate   = fastRate;
    next_wordValid  = 1'b0;
    next_configWord = configWord;

    if (riseEdge)
    begin
      next_sclk = 1'b1;
      if (state != ST_CMD)
      begin
        next_inShift  = inNext;
        next_chainBit = serialSync;
        next_bitCnt   = bitCnt + 6'h1;
      end
      else
        next_bitCnt = bitCnt + 6'h1;
      if (state == ST_PAYLOAD)
      begin
        next_crc = crcStep;
        if (bitCnt == 6'(WORD_BITS - 1))
        begin
          next_configWord = inNext;
          next_wordValid  = 1'b1;
        end
      end
    end
    else if (fallEdge)
    begin
      next_sclk     = 1'b0;
      next_cmdShift = {cmdShift[30:0], 1'b0};
    end

    case (state)
      ST_HOLD:
      begin
        if (progSync)
          next_state = ST_CLEAR;
      end
      ST_CLEAR:
      begin
        next_clearCnt = clearCnt + 20'h0_0001;
        if (clearCnt == CLEAR_LAST)
          next_state = ST_WAIT_INIT;
      end
      ST_WAIT_INIT:
      begin
        // an outside agent may keep init low until the flash wakes
        if (initSync)
        begin
          if (modeSync == MODE_SERIAL_FLASH)
          begin
            next_state    = ST_CMD;
            next_cmdShift = {FLASH_READ_CMD, FLASH_START_ADDR};
            next_bitCnt   = 6'h0;
          end
          else
            next_state = ST_BAD_MODE;
        end
      end
      ST_CMD:
      begin
        if (phaseEnd)
        begin
          next_state  = ST_HEADER;
          next_bitCnt = 6'h0;
        end
      end
      ST_HEADER:
      begin
        if (phaseEnd)
        begin
          next_state    = ST_PAYLOAD;
          next_bitCnt   = 6'h0;
          next_fastRate = inShift[HDR_FAST_BIT];
          next_crc      = CRC_INIT;
          next_wordCnt  = 16'h0;
        end
      end
      ST_PAYLOAD:
      begin
        if (phaseEnd)
        begin
          next_bitCnt  = 6'h0;
          next_wordCnt = wordCnt + 16'h1;
          if (wordCnt == WORD_LAST)
            next_state = ST_CRC;
        end
      end
      ST_CRC:
      begin
        if (phaseEnd)
        begin
          // no retry: a bad load waits for reprogram
          if (inShift[15:0] == crc)
            next_state = ST_DONE;
          else
            next_state = ST_CRC_ERR;
        end
      end
      ST_DONE, ST_CRC_ERR, ST_BAD_MODE:
      begin
        next_sclk = 1'b0;
      end
      default:
      begin
        next_state = ST_CLEAR;
      end
    endcase

    // a held reprogram overrides the next state and aborts the load; configWord, inShift, crc and wordCnt keep their values
    if (progHeld)
    begin
      next_state    = ST_HOLD;
      next_clearCnt = 20'h0_0000;
      next_sclk     = 1'b0;
      next_fastRate = 1'b0;
      next_bitCnt   = 6'h0;
      next_cmdShift = 32'h0000_0000;
      next_chainBit = 1'b0;
    end
  end

  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      state    <= ST_CLEAR;
      clearCnt <= 20'h0_0000;
      sclk     <= 1'b0;
      fastRate <= 1'b0;
    end
    else
    begin
      state    <= next_state;
      clearCnt <= next_clearCnt;
      sclk     <= next_sclk;
      fastRate <= next_fastRate;
    end
  end

  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      bitCnt   <= 6'h0;
      wordCnt  <= 16'h0;
      cmdShift <= 32'h0000_0000;
      inShift  <= 32'h0000_0000;
      crc      <= CRC_INIT;
      chainBit <= 1'b0;
    end
    else
    begin
      bitCnt   <= next_bitCnt;
      wordCnt  <= next_wordCnt;
      cmdShift <= next_cmdShift;
      inShift  <= next_inShift;
      crc      <= next_crc;
      chainBit <= next_chainBit;
    end
  end

  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      configWord      <= 32'h0000_0000;
      configWordValid <= 1'b0;
    end
    else
    begin
      configWord      <= next_configWord;
      configWordValid <= next_wordValid;
    end
  end

endmodule // serial_flash_config_master

// >>> dv/serial_flash_config_master_chk.sv
// Purpose: port checks on the serial flash configuration master
// Assumes: one core_clk domain, synchronous active-high reset
// Notes: bound into every master instance
`timescale 1ns/1ps
module serial_flash_config_master_chk
  import flash_cfg_pkg::*;
(
  // clock and reset
  input wire logic       core_clk,
  input wire logic       rst,
  // flash pins
  input wire flashPins_s pinOut,
  input wire flashPins_s pinOe,
  // control and status
  input wire logic       initIn,
  input wire logic       initOe,
  input wire logic       doneOe,
  input wire logic       reprogram_n,
  input wire logic       configWordValid,
  input wire logic       configDone,
  input wire logic       crcError,
  input wire logic       modeError
);
  // raw low-time count of the reprogram pin, saturating
  logic [3:0] progRawCnt;
  always_ff @(posedge core_clk)
  begin
    if (rst || reprogram_n)
      progRawCnt <= 4'h0;
    else if (progRawCnt != 4'hF)
      progRawCnt <= progRawCnt + 4'h1;
  end
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);
  // ten raw cycles covers sync delay, hold must follow shortly
  sequence progLong;
    (progRawCnt >= 4'h9) && !reprogram_n;
  endsequence
  sequence slowFirstHalf;
    (!pinOut.configClockOut) [*8] ##[16:17] pinOut.configClockOut;
  endsequence
  AST_CLEAR_INIT: assert property ($fell(rst) |-> initOe)
    else $error("init not low at start of clearing");
  AST_HOLD_HIZ: assert property (progLong |-> ##[0:6] (pinOe == '0 && !initOe && !doneOe))
    else $error("pins not released while reprogram held");
  AST_SEL_AFTER_INIT: assert property ($fell(pinOut.flashSelectN) |->
    initIn && !initOe && reprogram_n && pinOe.flashSelectN)
    else $error("select before init released");
  AST_SLOW_START: assert property ($fell(pinOut.flashSelectN) |-> slowFirstHalf)
    else $error("first clock half not slow");
  AST_CHAIN_DRIVEN: assert property (!pinOut.flashSelectN |->
    pinOe.chainOut && pinOe.configClockOut && pinOe.serialOut)
    else $error("link pins not driven during load");
  AST_MOSI_EDGE: assert property (!pinOut.flashSelectN && $changed(pinOut.serialOut) |->
    !pinOut.configClockOut)
    else $error("serial out moved with clock high");
  AST_DONE_FLAG: assert property (configDone |-> !doneOe && !initOe && pinOe == '0)
    else $error("done state pins wrong");
  AST_DONE_LOW: assert property (pinOe.flashSelectN |-> doneOe && !configDone)
    else $error("done released during load");
  AST_CRC_INIT: assert property (crcError |-> initOe && doneOe && pinOut.flashSelectN)
    else $error("crc error not flagged on init");
  AST_WORD_PULSE: assert property (configWordValid |-> !pinOut.flashSelectN ##1 !configWordValid)
    else $error("word valid not a single pulse");
  AST_MODE_ERR: assert property (modeError |-> pinOut.flashSelectN && !initOe && doneOe)
    else $error("bad mode touched the flash");
endmodule // serial_flash_config_master_chk

bind serial_flash_config_master serial_flash_config_master_chk u_chk (
  .core_clk(core_clk), .rst(rst), .pinOut(pinOut), .pinOe(pinOe), .initIn(initIn),
  .initOe(initOe), .doneOe(doneOe), .reprogram_n(reprogram_n), .configWordValid(configWordValid),
  .configDone(configDone), .crcError(crcError), .modeError(modeError));

// >>> dv/flash_model.sv
// Purpose: behavioural serial flash answering reads
// Assumes: mode 0, data out after falling clock edge
// Notes: released data line toggles every cycle
`timescale 1ns/1ps
module flash_model
(
  // clock and flash pins
  input  wire logic         core_clk,
  input  wire logic         selN,
  input  wire logic         sck,
  input  wire logic         mosi,
  // bits to answer with
  input  wire logic [111:0] stream,
  output logic              miso,
  output logic [31:0]       cmdWord,
  output int                selCount
);
  logic sckPrev = 1'b0;
  logic selPrev = 1'b1;
  int   rises   = 0;
  int   idx     = 0;
  initial miso = 1'b0;
  initial cmdWord = '0;
  initial selCount = 0;
  always @(posedge core_clk)
  begin
    sckPrev <= sck;
    selPrev <= selN;
    if (selPrev && !selN)
      selCount <= selCount + 1;
    if (selN)
    begin
      rises <= 0;
      idx   <= 0;
      miso  <= ~miso; // never stale when deselected
    end
    else if (sck && !sckPrev)
    begin
      rises <= rises + 1;
      if (rises < 32)
        cmdWord <= {cmdWord[30:0], mosi};
    end
    else if (!sck && sckPrev && rises >= 32 && idx < 112)
    begin
      miso <= stream[111 - idx];
      idx  <= idx + 1;
    end
  end
endmodule // flash_model

// >>> dv/serial_flash_config_master_tb_top.sv
// Purpose: self-checking bench for the configuration master
// Assumes: shortened clear time and two payload words
// Notes: rate option kept at 0 to 2, rate 3 leaves no setup
`timescale 1ns/1ps
module serial_flash_config_master_tb_top;
  import flash_cfg_pkg::*;
  logic         core_clk = 1'b0;
  logic         rst = 1'b1;
  logic         reprogram_n = 1'b1;
  logic         extHold = 1'b0;
  logic [2:0]   modeSelect = 3'h1;
  logic [1:0]   clock_rate_option = 2'h0;
  logic [111:0] stream = '0;
  flashPins_s   pinOut;
  flashPins_s   pinOe;
  logic         serialIn, initLine, selLine, sckLine, initOe, doneOe;
  logic         configWordValid, configDone, crcError, modeError, fastRate;
  logic [31:0]  configWord, cmdWord;
  int           selCount, sel0, fail_count = 0, compares = 0, seed = 32'h56c3;
  logic [31:0]  expQ[$], gotQ[$];
  always #(CLK_PERIOD_NS / 2) core_clk = ~core_clk;
  assign initLine = !(initOe || extHold);
  assign selLine = pinOe.flashSelectN ? pinOut.flashSelectN : 1'b1;
  assign sckLine = pinOe.configClockOut ? pinOut.configClockOut : 1'b0;
  serial_flash_config_master #(.CLEAR_TIME_NS(400), .PAYLOAD_WORDS(2)) u_dut (
    .core_clk(core_clk), .rst(rst), .pinOut(pinOut), .pinOe(pinOe), .serialIn(serialIn),
    .initIn(initLine), .initDrive(), .initOe(initOe), .doneDrive(), .doneOe(doneOe),
    .reprogram_n(reprogram_n), .modeSelect(modeSelect), .clock_rate_option(clock_rate_option),
    .configWord(configWord), .configWordValid(configWordValid), .configDone(configDone),
    .crcError(crcError), .modeError(modeError), .fastRate(fastRate));
  flash_model u_flash (.core_clk(core_clk), .selN(selLine), .sck(sckLine), .mosi(pinOut.serialOut),
    .stream(stream), .miso(serialIn), .cmdWord(cmdWord), .selCount(selCount));
  always @(posedge core_clk)
    if (configWordValid === 1'b1)
      gotQ.push_back(configWord);
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp)
    begin
      fail_count++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic finish_test();
    $display("counts: compares=%0d mismatches=%0d", compares, fail_count);
    if (fail_count == 0 && compares > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  function automatic logic [15:0] crc16(input logic [63:0] d);
    logic [15:0] c;
    c = CRC_INIT;
    for (int i = 63; i >= 0; i--)
      c = {c[14:0], 1'b0} ^ ((c[15] ^ d[i]) ? CRC_POLY : 16'h0000);
    return c;
  endfunction
  task automatic waitEnd();
    int i;
    for (i = 0; i < 20000 && configDone !== 1'b1 && crcError !== 1'b1 && modeError !== 1'b1; i++)
      @(posedge core_clk);
    if (i == 20000)
    begin
      fail_count++;
      finish_test();
    end
    repeat (4) @(posedge core_clk);
  endtask
  // restart by a long reprogram pulse, then load one image
  task automatic load(input logic fast, input logic badCrc, input logic [2:0] mode, input logic hold);
    logic [31:0] hdr, w0, w1;
    hdr = $random(seed);
    hdr[HDR_FAST_BIT] = fast;
    w0 = $random(seed);
    w1 = $random(seed);
    expQ = '{w0, w1};
    gotQ = {};
    stream <= {hdr, w0, w1, crc16({w0, w1}) ^ {15'h0000, badCrc}};
    modeSelect <= mode;
    clock_rate_option <= 2'($unsigned($random(seed)) % 3);
    sel0 = selCount;
    extHold <= hold;
    reprogram_n <= 1'b0;
    repeat (PROG_MIN_CYC + 4) @(posedge core_clk);
    reprogram_n <= 1'b1;
    repeat (8) @(posedge core_clk);
    check({initOe, doneOe}, 2'b11);
    if (hold)
    begin
      repeat (300) @(posedge core_clk);
      check({pinOut.flashSelectN, initOe, doneOe}, 3'b101);
      extHold <= 1'b0;
    end
    waitEnd();
  endtask
  task automatic checkGood(input logic fast);
    check(gotQ.size(), 2);
    for (int k = 0; k < 2; k++)
      check(gotQ[k], expQ[k]);
    check({configDone, doneOe, crcError, fastRate}, {3'b100, fast});
    check(pinOe, 4'h0);
    check(cmdWord, {FLASH_READ_CMD, FLASH_START_ADDR});
    check(pinOut.chainOut, stream[0]);
    check(selCount - sel0, 1);
  endtask
  initial
  begin
    repeat (5) @(posedge core_clk);
    rst <= 1'b0;
    for (int f = 0; f < 2; f++)
    begin
      load(f[0], 1'b0, MODE_SERIAL_FLASH, 1'b0);
      checkGood(f[0]);
      $display("test load fast=%0d done", f);
    end
    load(1'b0, 1'b1, MODE_SERIAL_FLASH, 1'b0);
    repeat (2000) @(posedge core_clk);
    check({crcError, initOe, doneOe, configDone}, 4'hE);
    check(selCount - sel0, 1);
    $display("test crc error done");
    for (int m = 0; m < 8; m++)
      if (m != 1)
      begin
        load(1'b0, 1'b0, 3'(m), 1'b0);
        check({modeError, pinOut.flashSelectN, initOe, doneOe}, 4'hD);
        check(selCount - sel0, 0);
      end
    $display("test modes done");
    load(1'b0, 1'b0, MODE_SERIAL_FLASH, 1'b1);
    checkGood(1'b0);
    // short pulse must not disturb a finished load
    reprogram_n <= 1'b0;
    repeat (PROG_MIN_CYC / 2) @(posedge core_clk);
    reprogram_n <= 1'b1;
    repeat (20) @(posedge core_clk);
    check(configDone, 1'b1);
    reprogram_n <= 1'b0;
    repeat (40) @(posedge core_clk);
    check({pinOut.flashSelectN, pinOe, initOe, doneOe, configDone}, 8'h80);
    $display("test reprogram done");
    finish_test();
  end
endmodule // serial_flash_config_master_tb_top
